// File: shared/cal_cfg_pkg.sv
/*
  Constants for the calibration and channel configuration register bank.
  Assumes a 16-bit register word and word-indexed addresses.
*/
package cal_cfg_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CAL_W  = 24;

  // --------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_GAIN0_UPPER = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_GAIN0_LOWER = 6'h0D;
  localparam logic [ADDR_W-1:0] OFS_CH1_CONFIG  = 6'h0E;
  localparam logic [ADDR_W-1:0] OFS_OFS1_UPPER  = 6'h0F;
  localparam logic [ADDR_W-1:0] OFS_OFS1_LOWER  = 6'h10;

  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_GAIN0_UPPER = 16'h8000;
  localparam logic [DATA_W-1:0] RST_GAIN0_LOWER = 16'h0000;
  localparam logic [DATA_W-1:0] RST_CH1_CONFIG  = 16'h0000;
  localparam logic [DATA_W-1:0] RST_OFS1_UPPER  = 16'h0000;
  localparam logic [DATA_W-1:0] RST_OFS1_LOWER  = 16'h0000;

  // --------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------
  localparam int unsigned LOWER_BYTE_LSB = 8;
  localparam int unsigned PHASE_LSB      = 6;
  localparam int unsigned PHASE_W        = 10;
  localparam int unsigned DC_OFF_BIT     = 2;
  localparam int unsigned MUX_LSB        = 0;
  localparam int unsigned MUX_W          = 2;

  typedef enum logic [1:0] {
    MUX_NORMAL  = 2'h0,
    MUX_SHORTED = 2'h1,
    MUX_POS_DC  = 2'h2,
    MUX_NEG_DC  = 2'h3
  } input_sel_e;

endpackage : cal_cfg_pkg

// File: rtl/cal_word_reg.sv
/*
  One 24-bit calibration word held as a full upper register and the
  high byte of a lower register. Assumes one-cycle write strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module cal_word_reg
  import cal_cfg_pkg::*;
#(
  parameter logic [DATA_W-1:0] UPPER_RST = 16'h0000,
  parameter logic [DATA_W-1:0] LOWER_RST = 16'h0000
) (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              wr_upper,
  input  wire logic              wr_lower,
  input  wire logic [DATA_W-1:0] wdata,
  output var  logic [DATA_W-1:0] upper_q,
  output var  logic [DATA_W-1:0] lower_q,
  output var  logic [CAL_W-1:0]  word_q
);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      upper_q <= UPPER_RST;
    end else if (wr_upper) begin
      upper_q <= wdata;
    end
  end

  // low byte never stored, so it always reads zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lower_q <= LOWER_RST;
    end else if (wr_lower) begin
      lower_q <= {wdata[DATA_W-1:LOWER_BYTE_LSB], 8'h00};
    end
  end

  // registered so the consumer copy matches the pair the cycle after a write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      word_q <= {UPPER_RST, LOWER_RST[DATA_W-1:LOWER_BYTE_LSB]};
    end else begin
      word_q <= {(wr_upper ? wdata : upper_q),
                 (wr_lower ? wdata[DATA_W-1:LOWER_BYTE_LSB]
                           : lower_q[DATA_W-1:LOWER_BYTE_LSB])};
    end
  end

endmodule : cal_word_reg
`default_nettype wire

// File: rtl/cal_cfg_regs.sv
/*
  Register bank for channel 0 gain, channel 1 offset and channel 1 config.
  Assumes a host-interface front end that issues one-cycle read and write
  strobes on a word address; read data is valid the cycle after.
*/
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - gain upper register is 16 read/write bits, gain word bits 23..8.
// - gain lower bits 15..8 store gain bits 7..0; low byte reads zero.
// - gain upper resets to 8000h, gain lower to zero.
// - config bits 15..6 hold a signed 10-bit phase delay in modulator cycles.
// - config bit 2 set turns channel 1 DC filter off; clear follows global.
// - config bits 1..0 pick normal, shorted, positive or negative test input.
// - config bits 5..3 read zero; config resets to 0000h.
// - offset upper register is 16 read/write bits, resets zero, bits 23..8.
// - offset lower bits 15..8 store offset bits 7..0; low byte reads zero.
module cal_cfg_regs
  import cal_cfg_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic [ADDR_W-1:0]  addr,
  input  wire logic [DATA_W-1:0]  wdata,
  input  wire logic               wr_stb,
  input  wire logic               rd_stb,
  input  wire logic               global_dc_filter_setting,
  output var  logic [DATA_W-1:0]  rdata,
  output var  logic [CAL_W-1:0]   gain0_word,
  output var  logic [CAL_W-1:0]   offset1_word,
  output var  logic [PHASE_W-1:0] second_channel_phase_delay,
  output var  logic               second_channel_dc_filter_off,
  output var  logic               ch1_dc_filter_active,
  output var  logic [MUX_W-1:0]   second_channel_input_select
);

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, OFS_GAIN0_UPPER) || hit(a, OFS_GAIN0_LOWER) || hit(a, OFS_CH1_CONFIG)
          || hit(a, OFS_OFS1_UPPER) || hit(a, OFS_OFS1_LOWER);
  endfunction : mapped

  logic [DATA_W-1:0] gain_word_upper;
  logic [DATA_W-1:0] gain_word_lower;
  logic [DATA_W-1:0] offset_word_upper;
  logic [DATA_W-1:0] offset_word_lower;
  logic [DATA_W-1:0] cfg_q;
  logic [DATA_W-1:0] rdata_d;

  // --------------------------------------------------------------
  // calibration words
  // --------------------------------------------------------------
  cal_word_reg #(
    .UPPER_RST (RST_GAIN0_UPPER),
    .LOWER_RST (RST_GAIN0_LOWER)
  ) u_gain0 (
    .clock    (clock),
    .rst_b    (rst_b),
    .wr_upper (wr_stb && hit(addr, OFS_GAIN0_UPPER)),
    .wr_lower (wr_stb && hit(addr, OFS_GAIN0_LOWER)),
    .wdata    (wdata),
    .upper_q  (gain_word_upper),
    .lower_q  (gain_word_lower),
    .word_q   (gain0_word)
  );

  cal_word_reg #(
    .UPPER_RST (RST_OFS1_UPPER),
    .LOWER_RST (RST_OFS1_LOWER)
  ) u_ofs1 (
    .clock    (clock),
    .rst_b    (rst_b),
    .wr_upper (wr_stb && hit(addr, OFS_OFS1_UPPER)),
    .wr_lower (wr_stb && hit(addr, OFS_OFS1_LOWER)),
    .wdata    (wdata),
    .upper_q  (offset_word_upper),
    .lower_q  (offset_word_lower),
    .word_q   (offset1_word)
  );

  // --------------------------------------------------------------
  // channel 1 configuration
  // --------------------------------------------------------------
  // reserved bits masked on write, so the stored copy already reads zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= RST_CH1_CONFIG;
    end else if (wr_stb && hit(addr, OFS_CH1_CONFIG)) begin
      cfg_q <= wdata & 16'hFFC7;
    end
  end

  logic [DATA_W-1:0] cfg_d;
  always_comb begin
    cfg_d = cfg_q;
    if (wr_stb && hit(addr, OFS_CH1_CONFIG)) begin
      cfg_d = wdata & 16'hFFC7;
    end
  end

  // outputs track the register with the same one-cycle latency
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      second_channel_phase_delay   <= RST_CH1_CONFIG[PHASE_LSB +: PHASE_W];
      second_channel_dc_filter_off <= RST_CH1_CONFIG[DC_OFF_BIT];
      second_channel_input_select  <= RST_CH1_CONFIG[MUX_LSB +: MUX_W];
    end else begin
      second_channel_phase_delay   <= cfg_d[PHASE_LSB +: PHASE_W];
      second_channel_dc_filter_off <= cfg_d[DC_OFF_BIT];
      second_channel_input_select  <= cfg_d[MUX_LSB +: MUX_W];
    end
  end

  // per-channel disable overrides; otherwise the global setting governs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ch1_dc_filter_active <= 1'b0;
    end else begin
      ch1_dc_filter_active <= !cfg_d[DC_OFF_BIT] && global_dc_filter_setting;
    end
  end

  // --------------------------------------------------------------
  // read port
  // --------------------------------------------------------------
  // unmapped addresses answer zero
  always_comb begin
    rdata_d = 16'h0000;
    unique case (1'b1)
      hit(addr, OFS_GAIN0_UPPER): rdata_d = gain_word_upper;
      hit(addr, OFS_GAIN0_LOWER): rdata_d = gain_word_lower;
      hit(addr, OFS_CH1_CONFIG):  rdata_d = cfg_q;
      hit(addr, OFS_OFS1_UPPER):  rdata_d = offset_word_upper;
      hit(addr, OFS_OFS1_LOWER):  rdata_d = offset_word_lower;
      default:                    rdata_d = 16'h0000;
    endcase
  end

  // data held only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rd_stb ? rdata_d : 16'h0000;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  gain_word_join_a: assert property (
    ##1 gain0_word == {gain_word_upper, gain_word_lower[15:8]})
    else $error("gain word does not match its registers");
  ofs_word_join_a: assert property (
    ##1 offset1_word == {offset_word_upper, offset_word_lower[15:8]})
    else $error("offset word does not match its registers");
  gain_upper_rw_a: assert property (
    wr_stb && addr == OFS_GAIN0_UPPER |=> gain_word_upper == $past(wdata))
    else $error("gain upper write lost");
  gain_low_zero_a: assert property (
    gain_word_lower[7:0] == 8'h00)
    else $error("gain lower reserved byte not zero");
  gain_low_readback_a: assert property (
    rd_stb && addr == OFS_GAIN0_LOWER |=> rdata[7:0] == 8'h00)
    else $error("gain lower read shows reserved bits");
  gain_reset_val_a: assert property (
    $rose(rst_b) && !wr_stb |-> gain0_word == 24'h800000)
    else $error("gain word reset value wrong");
  phase_out_a: assert property (
    wr_stb && addr == OFS_CH1_CONFIG |=> second_channel_phase_delay == $past(wdata[15:6]))
    else $error("phase delay not updated");
  dc_filter_a: assert property (
    ##1 ch1_dc_filter_active == (!second_channel_dc_filter_off && $past(global_dc_filter_setting)))
    else $error("dc filter state wrong");
  input_sel_a: assert property (
    wr_stb && addr == OFS_CH1_CONFIG |=> second_channel_input_select == $past(wdata[1:0]))
    else $error("input select not updated");
  cfg_resv_a: assert property (
    rd_stb && addr == OFS_CH1_CONFIG |=> rdata[5:3] == 3'h0)
    else $error("config reserved bits read nonzero");
  ofs_upper_rw_a: assert property (
    wr_stb && addr == OFS_OFS1_UPPER |=> ##1 offset1_word[23:8] == $past(wdata, 2))
    else $error("offset upper not reaching word");
  ofs_low_zero_a: assert property (
    offset_word_lower[7:0] == 8'h00)
    else $error("offset lower reserved byte not zero");

  // --------------------------------------------------------------
  // checks: stored fields
  // --------------------------------------------------------------
  gain_low_rw_a: assert property (
    wr_stb && addr == OFS_GAIN0_LOWER |=> gain_word_lower[15:8] == $past(wdata[15:8]))
    else $error("gain lower write lost");
  gain_low_word_a: assert property (
    wr_stb && addr == OFS_GAIN0_LOWER |=> gain0_word[7:0] == $past(wdata[15:8]))
    else $error("gain lower byte not reaching word");
  gain_upper_word_a: assert property (
    wr_stb && addr == OFS_GAIN0_UPPER |=> gain0_word[23:8] == $past(wdata))
    else $error("gain upper not reaching word");
  ofs_upper_reg_a: assert property (
    wr_stb && addr == OFS_OFS1_UPPER |=> offset_word_upper == $past(wdata))
    else $error("offset upper write lost");
  ofs_low_rw_a: assert property (
    wr_stb && addr == OFS_OFS1_LOWER |=> offset_word_lower == {$past(wdata[15:8]), 8'h00})
    else $error("offset lower write lost");
  ofs_low_word_a: assert property (
    wr_stb && addr == OFS_OFS1_LOWER |=> offset1_word[7:0] == $past(wdata[15:8]))
    else $error("offset lower byte not reaching word");
  dc_off_out_a: assert property (
    wr_stb && addr == OFS_CH1_CONFIG |=> second_channel_dc_filter_off == $past(wdata[2]))
    else $error("dc filter disable not updated");
  cfg_store_a: assert property (
    wr_stb && addr == OFS_CH1_CONFIG |=> cfg_q == ($past(wdata) & 16'hFFC7))
    else $error("config register stored wrong bits");

  // --------------------------------------------------------------
  // checks: registers hold between writes; disable keeps filter inactive
  // --------------------------------------------------------------
  gain_upper_hold_a: assert property (
    !(wr_stb && addr == OFS_GAIN0_UPPER) |=> $stable(gain_word_upper))
    else $error("gain upper changed without a write");
  gain_low_hold_a: assert property (
    !(wr_stb && addr == OFS_GAIN0_LOWER) |=> $stable(gain_word_lower))
    else $error("gain lower changed without a write");
  cfg_hold_a: assert property (
    !(wr_stb && addr == OFS_CH1_CONFIG) |=> $stable(cfg_q))
    else $error("config changed without a write");
  ofs_upper_hold_a: assert property (
    !(wr_stb && addr == OFS_OFS1_UPPER) |=> $stable(offset_word_upper))
    else $error("offset upper changed without a write");
  ofs_low_hold_a: assert property (
    !(wr_stb && addr == OFS_OFS1_LOWER) |=> $stable(offset_word_lower))
    else $error("offset lower changed without a write");
  unmapped_wr_a: assert property (
    wr_stb && !mapped(addr) |=> $stable(gain0_word) && $stable(offset1_word))
    else $error("write to unused address changed a word");
  dc_active_off_a: assert property (
    second_channel_dc_filter_off |-> !ch1_dc_filter_active)
    else $error("dc filter active while disabled");

  // --------------------------------------------------------------
  // checks: read port
  // --------------------------------------------------------------
  // reads show the register as it stood at the strobe
  rd_gain_upper_a: assert property (
    rd_stb && addr == OFS_GAIN0_UPPER |=> rdata == $past(gain_word_upper))
    else $error("gain upper read back wrong");
  rd_gain_low_a: assert property (
    rd_stb && addr == OFS_GAIN0_LOWER |=> rdata == $past(gain_word_lower))
    else $error("gain lower read back wrong");
  rd_cfg_a: assert property (
    rd_stb && addr == OFS_CH1_CONFIG |=> rdata == $past(cfg_q))
    else $error("config read back wrong");
  rd_ofs_upper_a: assert property (
    rd_stb && addr == OFS_OFS1_UPPER |=> rdata == $past(offset_word_upper))
    else $error("offset upper read back wrong");
  rd_ofs_low_a: assert property (
    rd_stb && addr == OFS_OFS1_LOWER |=> rdata == $past(offset_word_lower))
    else $error("offset lower read back wrong");
  rd_unmapped_a: assert property (
    rd_stb && !mapped(addr) |=> rdata == 16'h0000)
    else $error("unused address read nonzero");
  rd_idle_a: assert property (
    !rd_stb |=> rdata == 16'h0000)
    else $error("read data stands past its cycle");

  // --------------------------------------------------------------
  // checks: values right after reset
  // --------------------------------------------------------------
  cfg_reset_a: assert property (
    $rose(rst_b) |-> cfg_q == RST_CH1_CONFIG && second_channel_phase_delay == 10'h000
      && second_channel_input_select == 2'h0 && !second_channel_dc_filter_off)
    else $error("config reset value wrong");
  ofs_reset_a: assert property (
    $rose(rst_b) |-> offset1_word == 24'h000000 && offset_word_lower == RST_OFS1_LOWER)
    else $error("offset word reset value wrong");
  gain_regs_reset_a: assert property (
    $rose(rst_b) |-> gain_word_lower == RST_GAIN0_LOWER
      && gain_word_upper == RST_GAIN0_UPPER)
    else $error("gain register reset value wrong");
  dc_active_reset_a: assert property (
    $rose(rst_b) |-> !ch1_dc_filter_active)
    else $error("dc filter active out of reset");

  // --------------------------------------------------------------
  // cover points
  // --------------------------------------------------------------
  wr_cfg_c:  cover property (wr_stb && addr == OFS_CH1_CONFIG ##1 rd_stb && addr == OFS_CH1_CONFIG);
  wr_gain_c: cover property (wr_stb && addr == OFS_GAIN0_LOWER ##1 wr_stb && addr == OFS_GAIN0_UPPER);
  dc_off_c:  cover property (second_channel_dc_filter_off && global_dc_filter_setting);
  neg_dc_c:  cover property (second_channel_input_select == MUX_NEG_DC);
  neg_ph_c:  cover property (second_channel_phase_delay[PHASE_W-1] &&
                             second_channel_input_select == MUX_SHORTED);

endmodule : cal_cfg_regs
`default_nettype wire

// File: bench/tb_cal_cfg_regs.sv
/*
  Self-checking bench for the calibration and channel configuration bank.
  Assumes a single 200 MHz clock and the plain strobe register port.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_cal_cfg_regs
  import cal_cfg_pkg::*;
;
  logic               clock = 1'b0;
  logic               rst_b = 1'b0;
  logic [ADDR_W-1:0]  addr = '0;
  logic [DATA_W-1:0]  wdata = '0;
  logic               wr_stb = 1'b0;
  logic               rd_stb = 1'b0;
  logic               global_dc_filter_setting = 1'b0;
  logic [DATA_W-1:0]  rdata;
  logic [CAL_W-1:0]   gain0_word;
  logic [CAL_W-1:0]   offset1_word;
  logic [PHASE_W-1:0] second_channel_phase_delay;
  logic               second_channel_dc_filter_off;
  logic               ch1_dc_filter_active;
  logic [MUX_W-1:0]   second_channel_input_select;
  int                 errors = 0;
  int                 cmp_count = 0;

  always #2.5 clock = ~clock;

  cal_cfg_regs dut (
    .clock                        (clock),
    .rst_b                        (rst_b),
    .addr                         (addr),
    .wdata                        (wdata),
    .wr_stb                       (wr_stb),
    .rd_stb                       (rd_stb),
    .global_dc_filter_setting     (global_dc_filter_setting),
    .rdata                        (rdata),
    .gain0_word                   (gain0_word),
    .offset1_word                 (offset1_word),
    .second_channel_phase_delay   (second_channel_phase_delay),
    .second_channel_dc_filter_off (second_channel_dc_filter_off),
    .ch1_dc_filter_active         (ch1_dc_filter_active),
    .second_channel_input_select  (second_channel_input_select)
  );

  // --------------------------------------------------------------
  // bus tasks
  // --------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    #1;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask : rd_chk

  task automatic do_reset();
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    #1;
  endtask : do_reset

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset_values();
    `CHK("gain_word", 24'h800000, gain0_word)
    `CHK("offset_word", 24'h000000, offset1_word)
    `CHK("phase", 10'h000, second_channel_phase_delay)
    `CHK("select", 2'h0, second_channel_input_select)
    `CHK("dc_off", 1'b0, second_channel_dc_filter_off)
    `CHK("dc_active", 1'b0, ch1_dc_filter_active)
    rd_chk(OFS_GAIN0_UPPER, 16'h8000);
    rd_chk(OFS_GAIN0_LOWER, 16'h0000);
    rd_chk(OFS_CH1_CONFIG, 16'h0000);
    rd_chk(OFS_OFS1_UPPER, 16'h0000);
    rd_chk(OFS_OFS1_LOWER, 16'h0000);
  endtask : t_reset_values

  task automatic t_cal_words();
    wr(OFS_GAIN0_UPPER, 16'h1234);
    wr(OFS_GAIN0_LOWER, 16'hABFF);
    wr(OFS_OFS1_UPPER, 16'hFEDC);
    wr(OFS_OFS1_LOWER, 16'h5A5A);
    `CHK("gain_word", 24'h1234AB, gain0_word)
    `CHK("offset_word", 24'hFEDC5A, offset1_word)
    rd_chk(OFS_GAIN0_UPPER, 16'h1234);
    rd_chk(OFS_GAIN0_LOWER, 16'hAB00);
    rd_chk(OFS_OFS1_UPPER, 16'hFEDC);
    rd_chk(OFS_OFS1_LOWER, 16'h5A00);
    // a lower write alone leaves the upper half in place
    wr(OFS_GAIN0_LOWER, 16'h0100);
    `CHK("gain_word", 24'h123401, gain0_word)
  endtask : t_cal_words

  task automatic t_config();
    logic [DATA_W-1:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {10'h200 | 10'(i), 3'h7, i[0], i[1:0]};
      wr(OFS_CH1_CONFIG, v);
      `CHK("phase", 10'h200 | 10'(i), second_channel_phase_delay)
      `CHK("dc_off", i[0], second_channel_dc_filter_off)
      `CHK("select", i[1:0], second_channel_input_select)
      rd_chk(OFS_CH1_CONFIG, v & 16'hFFC7);
    end
  endtask : t_config

  task automatic t_dc_filter();
    wr(OFS_CH1_CONFIG, 16'h0000);
    @(posedge clock);
    global_dc_filter_setting <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    `CHK("dc_active", 1'b1, ch1_dc_filter_active)
    wr(OFS_CH1_CONFIG, 16'h0004);
    @(posedge clock);
    #1;
    `CHK("dc_active", 1'b0, ch1_dc_filter_active)
    wr(OFS_CH1_CONFIG, 16'h0000);
    `CHK("dc_active", 1'b1, ch1_dc_filter_active)
    @(posedge clock);
    global_dc_filter_setting <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    `CHK("dc_active", 1'b0, ch1_dc_filter_active)
  endtask : t_dc_filter

  task automatic t_unmapped();
    wr(6'h11, 16'hFFFF);
    wr(6'h0B, 16'hFFFF);
    rd_chk(6'h11, 16'h0000);
    rd_chk(6'h0B, 16'h0000);
    rd_chk(OFS_OFS1_UPPER, 16'hFEDC);
    @(posedge clock);
    #1;
    `CHK("rdata_idle", 16'h0000, rdata)
  endtask : t_unmapped

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    tally_and_finish();
  end

  initial begin
    do_reset();
    t_reset_values();
    t_cal_words();
    t_config();
    t_dc_filter();
    t_unmapped();
    // mid-run reset must restore every register
    wr(OFS_CH1_CONFIG, 16'hFFFF);
    do_reset();
    t_reset_values();
    tally_and_finish();
  end
endmodule : tb_cal_cfg_regs
`default_nettype wire
